// ---- verilog/hfx_ctrl.sv ----
// frame start trigger and exposure control with apb registers
`timescale 1ns/1ns
`include "hfx_defs.svh"

module hfx_ctrl #(
   parameter int TW    = 20,
   parameter int LINES = 2
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire hfx_pkg::hfx_apb_req_t apb_req,
   output hfx_pkg::hfx_apb_rsp_t    apb_rsp,
   input  wire logic [LINES-1:0]    ext_frame_trigger_in,
   output hfx_pkg::hfx_cam_t        cam,
   output logic                     irq
);
   import hfx_pkg::*;

   hfx_ctrl_t        ctrl;
   logic [TW-1:0]    exposure_duration_us;
   logic [TW-1:0]    trigger_delay_us;
   hfx_state_t       state;
   hfx_state_t       next_state;
   logic [LINES-1:0] line_meta;
   logic [LINES-1:0] line_sync;
   logic [LINES-1:0] line_prev;
   logic [2:0]       int_stat;
   logic [2:0]       int_mask;
   logic [4:0]       cyc_cnt;
   logic [TW-1:0]    us_cnt;
   logic             us_tick;
   logic             pw_frame;
   logic             line_idx;
   logic             sel_lvl;
   logic             sel_prev;
   logic             lvl_active;
   logic             act_edge;
   logic             hw_trig;
   logic             sw_trig;
   logic             int_start;
   logic             trig_req;
   logic             accept;
   logic             over;
   logic             use_delay;
   logic             expo_done;
   logic             min_elapsed;
   logic             wr_en;
   logic             rd_setup;
   logic             rd_clr;
   logic             mapped;
   logic [31:0]      rd_val;
   logic [31:0]      prdata_q;
   logic [2:0]       events;

   function automatic logic acc(input hfx_apb_req_t r, input logic [7:0] off);
      return r.psel && r.penable && r.paddr == off;
   endfunction

   // apb handshake and decode
   assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign rd_clr   = acc(apb_req, `HFX_OFF_INT_STAT) && !apb_req.pwrite;

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0;
      unique case (apb_req.paddr)
         `HFX_OFF_CTRL: begin
            rd_val[`HFX_CTRL_TRIG_EN] = ctrl.frame_trigger_enable;
            rd_val[`HFX_CTRL_EDGE]    = ctrl.trigger_edge_select;
            rd_val[`HFX_CTRL_KIND]    = ctrl.exposure_kind_select;
            rd_val[`HFX_CTRL_ORIG_HI:`HFX_CTRL_ORIG_LO] = ctrl.trigger_origin_select;
            rd_val[`HFX_CTRL_RATE_EN] = ctrl.internal_rate_enable;
         end
         `HFX_OFF_EXPOSURE: rd_val[TW-1:0] = exposure_duration_us;
         `HFX_OFF_DELAY:    rd_val[TW-1:0] = trigger_delay_us;
         `HFX_OFF_STATUS:   rd_val[2:0]    = state;
         `HFX_OFF_INT_STAT: rd_val[2:0]    = int_stat;
         `HFX_OFF_INT_MASK: rd_val[2:0]    = int_mask;
         `HFX_OFF_COMMAND:  rd_val         = 32'h0;
         default:           mapped         = 1'b0;
      endcase
   end

   // zero wait states, read data from flop
   assign apb_rsp = '{prdata:  prdata_q,
                      pready:  1'b1,
                      pslverr: apb_req.psel && apb_req.penable && !mapped};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (rd_setup) begin
         prdata_q <= rd_val;
      end
   end

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl.frame_trigger_enable  <= 1'b0;
         ctrl.trigger_edge_select   <= 1'b0;
         ctrl.exposure_kind_select  <= 1'b0;
         ctrl.trigger_origin_select <= HFX_SRC_LINE1;
         ctrl.internal_rate_enable  <= 1'b0;
      end else if (wr_en && apb_req.paddr == `HFX_OFF_CTRL) begin
         ctrl.frame_trigger_enable  <= apb_req.pwdata[`HFX_CTRL_TRIG_EN];
         ctrl.trigger_edge_select   <= apb_req.pwdata[`HFX_CTRL_EDGE];
         ctrl.exposure_kind_select  <= apb_req.pwdata[`HFX_CTRL_KIND];
         ctrl.trigger_origin_select <=
            hfx_origin_t'(apb_req.pwdata[`HFX_CTRL_ORIG_HI:`HFX_CTRL_ORIG_LO]);
         ctrl.internal_rate_enable  <= apb_req.pwdata[`HFX_CTRL_RATE_EN];
      end
   end

   // timing registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exposure_duration_us <= TW'(`HFX_EXPOSURE_RST);
         trigger_delay_us     <= TW'(`HFX_DELAY_RST);
      end else if (wr_en) begin
         if (apb_req.paddr == `HFX_OFF_EXPOSURE) begin
            exposure_duration_us <= apb_req.pwdata[TW-1:0];
         end
         if (apb_req.paddr == `HFX_OFF_DELAY) begin
            trigger_delay_us <= apb_req.pwdata[TW-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_meta <= '0;
         line_sync <= '0;
         line_prev <= '0;
      end else begin
         line_meta <= ext_frame_trigger_in;
         line_sync <= line_meta;
         line_prev <= line_sync;
      end
   end

   assign line_idx   = ctrl.trigger_origin_select == HFX_SRC_LINE2;
   assign sel_lvl    = line_sync[line_idx];
   assign sel_prev   = line_prev[line_idx];
   assign lvl_active = sel_lvl ^ ctrl.trigger_edge_select;
   assign act_edge   = lvl_active && !(sel_prev ^ ctrl.trigger_edge_select);
   assign hw_trig    = ctrl.frame_trigger_enable &&
                       ctrl.trigger_origin_select != HFX_SRC_SOFT && act_edge;
   assign sw_trig    = ctrl.frame_trigger_enable &&
                       ctrl.trigger_origin_select == HFX_SRC_SOFT &&
                       wr_en && apb_req.paddr == `HFX_OFF_COMMAND &&
                       apb_req.pwdata[`HFX_CMD_SW_TRIG];
   assign int_start  = !ctrl.frame_trigger_enable && ctrl.internal_rate_enable;
   assign trig_req   = hw_trig || sw_trig || int_start;
   assign accept     = trig_req && state == HFX_IDLE;
   assign over       = (hw_trig || sw_trig) && state != HFX_IDLE;
   assign use_delay  = hw_trig && trigger_delay_us != '0;

   // microsecond time base
   assign us_tick = cyc_cnt == 5'(`HFX_TICK_CYC - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_cnt <= 5'h0;
         us_cnt  <= '0;
      end else if (next_state != state) begin
         cyc_cnt <= 5'h0;
         us_cnt  <= '0;
      end else if (us_tick) begin
         cyc_cnt <= 5'h0;
         us_cnt  <= us_cnt + TW'(1);
      end else begin
         cyc_cnt <= cyc_cnt + 5'h1;
      end
   end

   // pulse width applies to hardware frames only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_frame <= 1'b0;
      end else if (accept) begin
         pw_frame <= ctrl.exposure_kind_select && hw_trig;
      end
   end

   assign expo_done   = pw_frame ? !lvl_active : us_cnt == exposure_duration_us;
   assign min_elapsed = us_cnt >= exposure_duration_us;

   always_comb begin
      next_state = state;
      unique case (state)
         HFX_IDLE: begin
            if (accept) begin
               next_state = use_delay ? HFX_DELAY : HFX_EXPOSE;
            end
         end
         HFX_DELAY: begin
            if (us_cnt == trigger_delay_us) begin
               next_state = HFX_EXPOSE;
            end
         end
         HFX_EXPOSE: begin
            if (expo_done) begin
               next_state = HFX_IDLE;
            end
         end
         default: next_state = HFX_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= HFX_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // camera side outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cam <= '{waiting: 1'b1, default: 1'b0};
      end else begin
         cam.waiting       <= next_state == HFX_IDLE;
         cam.exposing      <= next_state == HFX_EXPOSE;
         cam.frame_start   <= state != HFX_EXPOSE && next_state == HFX_EXPOSE;
         cam.overtrigger   <= over;
         cam.trigger_ready <= next_state == HFX_IDLE ||
                              (pw_frame && state == HFX_EXPOSE &&
                               next_state == HFX_EXPOSE && min_elapsed);
      end
   end

   // sticky interrupt status, set wins over read clear
   assign events[`HFX_INT_START] = state != HFX_EXPOSE && next_state == HFX_EXPOSE;
   assign events[`HFX_INT_OVER]  = over;
   assign events[`HFX_INT_END]   = state == HFX_EXPOSE && next_state == HFX_IDLE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= 3'h0;
      end else begin
         // clear only what the read reported
         int_stat <= (int_stat & ~(prdata_q[2:0] & {3{rd_clr}})) | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask <= `HFX_MASK_RST;
      end else if (wr_en && apb_req.paddr == `HFX_OFF_INT_MASK) begin
         int_mask <= apb_req.pwdata[2:0];
      end
   end

   assign irq = |(int_stat & int_mask);

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_line_trig_accept:
      assert property (state == HFX_IDLE && hw_trig |=> state != HFX_IDLE)
      else $error("line trigger not accepted");
   a_edge_polarity:
      assert property (hw_trig |-> sel_lvl != ctrl.trigger_edge_select &&
                       $past(sel_lvl) == ctrl.trigger_edge_select)
      else $error("trigger on wrong edge");
   a_wait_edge_start:
      assert property (state == HFX_IDLE && hw_trig && !use_delay |=>
                       cam.frame_start && cam.exposing)
      else $error("edge in waiting did not start exposure");
   a_leave_waiting:
      assert property ($rose(cam.exposing) |-> !cam.waiting)
      else $error("still waiting during exposure");
   a_return_waiting:
      assert property (state == HFX_EXPOSE && expo_done |=>
                       cam.waiting && state == HFX_IDLE)
      else $error("did not return to waiting");
   a_frame_per_accept:
      assert property (cam.frame_start |-> !$past(cam.exposing) ##1 !cam.frame_start)
      else $error("frame start not single");
   a_timed_length:
      assert property ($fell(state == HFX_EXPOSE) && !pw_frame |->
                       $past(us_cnt) == exposure_duration_us)
      else $error("timed exposure wrong length");
   a_overtrig_drop:
      assert property (over && !(state == HFX_DELAY && next_state == HFX_EXPOSE) |=>
                       cam.overtrigger && !cam.frame_start && int_stat[`HFX_INT_OVER])
      else $error("overtrigger not flagged");
   a_pw_end:
      assert property (state == HFX_EXPOSE && pw_frame && !lvl_active |=> state == HFX_IDLE)
      else $error("pulse width exposure not ended");
   a_pw_ready:
      assert property (cam.trigger_ready && cam.exposing |-> pw_frame && min_elapsed)
      else $error("ready during exposure without duration");
   a_delay_applied:
      assert property (accept && use_delay |=> state == HFX_DELAY)
      else $error("delay not applied");
   a_delay_bypass:
      assert property (accept && !hw_trig |=> state == HFX_EXPOSE)
      else $error("delay not bypassed");
   a_no_internal:
      assert property (!ctrl.internal_rate_enable && !hw_trig && !sw_trig |-> !accept)
      else $error("internal pacing while disabled");
   a_busy_ignore:
      assert property (state == HFX_EXPOSE && hw_trig && !expo_done |=> state == HFX_EXPOSE)
      else $error("busy trigger disturbed exposure");
   a_single_edge:
      assert property (hw_trig |=> !hw_trig)
      else $error("edge detected twice");
   a_event_sticky:
      assert property (events != 3'h0 |=> (int_stat & $past(events)) == $past(events))
      else $error("event not held in status");
   a_timed_no_ready:
      assert property (cam.exposing && !pw_frame |-> !cam.trigger_ready)
      else $error("ready during timed exposure");
   a_soft_timed:
      assert property (accept && !hw_trig |=> !pw_frame)
      else $error("software frame not timed");

   c_timed_frame: cover property (accept ##1 state == HFX_EXPOSE && !pw_frame);
   c_pw_frame:    cover property (state == HFX_EXPOSE && pw_frame ##1 state == HFX_IDLE);
   c_overtrig:    cover property (over);
   c_delayed:     cover property (state == HFX_DELAY ##1 state == HFX_EXPOSE);
   c_internal:    cover property (int_start && accept);

endmodule

// ---- verilog/hfx_defs.svh ----
// register map, field positions, reset values and timing for the frame trigger block
// Overview of operation
// - selected input line acts as frame trigger
// - edge select picks rising or falling
// - waiting status: selected edge starts frame
// - leave waiting at exposure, return when ready
// - one frame per external trigger period
// - two exposure modes: timed, pulse width
// - timed: expose for programmed duration
// - trigger during exposure dropped, overtrigger raised
// - pulse width: expose until opposite edge
// - pulse width: duration drives trigger ready
// - programmable microsecond delay before trigger acts
// - no delay when mode off or software
// - rate enable off: no internal pacing
// - triggers outside waiting status start no frame
// - input line 1 is reset trigger source
`ifndef HFX_DEFS_SVH
`define HFX_DEFS_SVH

`define HFX_OFF_CTRL      8'h00
`define HFX_OFF_EXPOSURE  8'h04
`define HFX_OFF_DELAY     8'h08
`define HFX_OFF_STATUS    8'h0c
`define HFX_OFF_INT_STAT  8'h10
`define HFX_OFF_INT_MASK  8'h14
`define HFX_OFF_COMMAND   8'h18

`define HFX_CTRL_TRIG_EN  0
`define HFX_CTRL_EDGE     1
`define HFX_CTRL_KIND     2
`define HFX_CTRL_ORIG_LO  4
`define HFX_CTRL_ORIG_HI  5
`define HFX_CTRL_RATE_EN  8
`define HFX_CMD_SW_TRIG   0

`define HFX_INT_START     0
`define HFX_INT_OVER      1
`define HFX_INT_END       2

`define HFX_EXPOSURE_RST  32'h0000_0bb8
`define HFX_DELAY_RST     32'h0000_0000
`define HFX_MASK_RST      3'h0

`define HFX_CLK_MHZ       25
`define HFX_TICK_US       1
`define HFX_TICK_CYC      (`HFX_TICK_US * `HFX_CLK_MHZ)

`endif

// ---- verilog/hfx_pkg.sv ----
// types shared by the frame trigger block
package hfx_pkg;

   typedef enum logic [2:0] {
      HFX_IDLE   = 3'b001,
      HFX_DELAY  = 3'b010,
      HFX_EXPOSE = 3'b100
   } hfx_state_t;

   typedef enum logic [1:0] {
      HFX_SRC_LINE1 = 2'h0,
      HFX_SRC_LINE2 = 2'h1,
      HFX_SRC_SOFT  = 2'h2
   } hfx_origin_t;

   typedef struct packed {
      logic        frame_trigger_enable;
      logic        trigger_edge_select;
      logic        exposure_kind_select;
      hfx_origin_t trigger_origin_select;
      logic        internal_rate_enable;
   } hfx_ctrl_t;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } hfx_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } hfx_apb_rsp_t;

   typedef struct packed {
      logic waiting;
      logic exposing;
      logic trigger_ready;
      logic frame_start;
      logic overtrigger;
   } hfx_cam_t;

endpackage

// ---- tb/hfx_trig_src.sv ----
// external trigger source model driving both input lines
`timescale 1ns/1ns

module hfx_trig_src (
   input  wire logic pclk,
   output logic [1:0] lines
);
   initial lines = 2'h0;

   task automatic drive(input int ln, input logic v, input int hold);
      int n;
      n = (hold < 2) ? 2 : hold;
      @(posedge pclk);
      lines[ln] <= v;
      repeat (n) @(posedge pclk);
   endtask

   // one active level, then back to idle
   task automatic pulse(input int ln, input logic act, input int w);
      drive(ln, act, w);
      drive(ln, ~act, 4);
   endtask
endmodule

// ---- tb/test_hw_frame_trigger_exposure_ctrl.sv ----
// self-checking bench for the frame trigger and exposure block
`timescale 1ns/1ns
`include "hfx_defs.svh"

module test_hw_frame_trigger_exposure_ctrl;
   import hfx_pkg::*;
   logic         pclk;
   logic         presetn;
   hfx_apb_req_t req;
   hfx_apb_rsp_t apb_rsp;
   logic [1:0]   lines;
   hfx_cam_t     cam;
   logic         irq;
   int           bad_count, n_tests, cyc, fs_cnt, ot_cnt, t_fs, run, exp_len, wx, tre;
   int           e, w, d, t0, f0, o0, r0;
   logic [31:0]  q;
   logic         er;

   hfx_ctrl dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(apb_rsp),
                 .ext_frame_trigger_in(lines), .cam(cam), .irq(irq));
   hfx_trig_src src (.pclk(pclk), .lines(lines));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cam.frame_start === 1'b1) begin
         fs_cnt <= fs_cnt + 1;
         t_fs <= cyc;
      end
      if (cam.overtrigger === 1'b1) ot_cnt <= ot_cnt + 1;
      if (cam.exposing === 1'b1) run <= run + 1;
      else if (run != 0) begin
         exp_len <= run;
         run <= 0;
      end
      if (cam.exposing === 1'b1 && cam.waiting !== 1'b0) wx <= wx + 1;
      if (cam.exposing === 1'b1 && cam.trigger_ready === 1'b1) tre <= tre + 1;
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask

   function automatic logic [31:0] rng(input int v, input int lo, input int hi);
      return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
   endfunction

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
      @(posedge pclk);
      req.paddr <= a;
      req.pwrite <= wr;
      req.pwdata <= dt;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, q, x);
   endtask

   task automatic wait_idle();
      int i;
      repeat (6) @(posedge pclk);
      for (i = 0; i < 3000 && cam.waiting !== 1'b1; i++) @(posedge pclk);
      repeat (3) @(posedge pclk);
   endtask

   task automatic mark();
      t0 = cyc;
      f0 = fs_cnt;
      o0 = ot_cnt;
      r0 = tre;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      summarize();
   end

   initial begin
      req = '0;
      presetn = 1'b0;
      {bad_count, n_tests, cyc, fs_cnt, ot_cnt, t_fs, run, exp_len, wx, tre} = '0;
      void'($urandom(32'h3558));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctrl_rst", `HFX_OFF_CTRL, 32'h0);
      rdc("expo_rst", `HFX_OFF_EXPOSURE, 32'h0000_0bb8);
      rdc("delay_rst", `HFX_OFF_DELAY, 32'h0);
      rdc("mask_rst", `HFX_OFF_INT_MASK, 32'h0);
      rdc("stat_rst", `HFX_OFF_INT_STAT, 32'h0);
      rdc("bad_addr", 8'h20, 32'h0);
      chk("bad_err", er, 1'b1);
      chk("wait_rst", cam.waiting, 1'b1);
      $display("test reset done");
      e = 1 + $urandom % 3;
      apb(1'b1, `HFX_OFF_EXPOSURE, e);
      apb(1'b1, `HFX_OFF_CTRL, 32'h1);
      mark();
      src.pulse(0, 1'b1, 6);
      wait_idle();
      chk("timed_frames", fs_cnt - f0, 1);
      chk("timed_latency", rng(t_fs - t0, 2, 8), 1);
      chk("timed_len", rng(exp_len, e * 25, e * 25 + 2), 1);
      chk("wait_in_expo", wx, 0);
      $display("test timed done");
      apb(1'b0, `HFX_OFF_INT_STAT, 32'h0);
      mark();
      src.pulse(0, 1'b1, 4);
      src.pulse(0, 1'b1, 4);
      wait_idle();
      chk("over_frames", fs_cnt - f0, 1);
      chk("over_events", ot_cnt - o0, 1);
      rdc("stat_over", `HFX_OFF_INT_STAT, 32'h7);
      rdc("stat_clear", `HFX_OFF_INT_STAT, 32'h0);
      $display("test overtrigger done");
      src.drive(1, 1'b1, 4);
      apb(1'b1, `HFX_OFF_CTRL, 32'h13);
      mark();
      src.pulse(0, 1'b1, 4);
      wait_idle();
      chk("other_line", fs_cnt - f0, 0);
      src.pulse(1, 1'b0, 6);
      wait_idle();
      chk("falling_frame", fs_cnt - f0, 1);
      apb(1'b1, `HFX_OFF_CTRL, 32'h1);
      src.drive(1, 1'b0, 4);
      $display("test falling done");
      w = 40 + $urandom % 30;
      apb(1'b1, `HFX_OFF_EXPOSURE, 32'h1);
      apb(1'b1, `HFX_OFF_CTRL, 32'h5);
      mark();
      src.pulse(0, 1'b1, w);
      wait_idle();
      chk("width_frames", fs_cnt - f0, 1);
      chk("width_len", rng(exp_len, w - 1, w + 3), 1);
      chk("width_ready", rng(tre - r0, 1, w), 1);
      $display("test pulse width done");
      d = 1 + $urandom % 2;
      apb(1'b1, `HFX_OFF_CTRL, 32'h1);
      apb(1'b1, `HFX_OFF_DELAY, d);
      mark();
      src.pulse(0, 1'b1, 4);
      wait_idle();
      chk("delay_latency", rng(t_fs - t0, d * 25 + 2, d * 25 + 10), 1);
      apb(1'b1, `HFX_OFF_CTRL, 32'h21);
      mark();
      apb(1'b1, `HFX_OFF_COMMAND, 32'h1);
      wait_idle();
      chk("soft_frames", fs_cnt - f0, 1);
      chk("soft_nodelay", rng(t_fs - t0, 1, 12), 1);
      $display("test delay done");
      apb(1'b1, `HFX_OFF_DELAY, 32'h0);
      apb(1'b1, `HFX_OFF_CTRL, 32'h0);
      mark();
      src.pulse(0, 1'b1, 4);
      repeat (200) @(posedge pclk);
      chk("off_frames", fs_cnt - f0, 0);
      $display("test disabled done");
      mark();
      apb(1'b1, `HFX_OFF_CTRL, 32'h100);
      repeat (200) @(posedge pclk);
      apb(1'b1, `HFX_OFF_CTRL, 32'h0);
      wait_idle();
      chk("rate_frames", rng(fs_cnt - f0, 5, 9), 1);
      chk("rate_wait", wx, 0);
      $display("test internal rate done");
      apb(1'b0, `HFX_OFF_INT_STAT, 32'h0);
      apb(1'b1, `HFX_OFF_CTRL, 32'h1);
      src.pulse(0, 1'b1, 4);
      wait_idle();
      chk("irq_masked", irq, 1'b0);
      apb(1'b1, `HFX_OFF_INT_MASK, 32'h1);
      @(posedge pclk);
      chk("irq_raised", irq, 1'b1);
      rdc("stat_frame", `HFX_OFF_INT_STAT, 32'h5);
      @(posedge pclk);
      chk("irq_cleared", irq, 1'b0);
      $display("test interrupt done");
      summarize();
   end
endmodule
